// ---- logic/secure_rtc.sv ----
// secure clock extensions: clock output, wakeup pin, seconds pulse, monotonic counter,
// tamper time capture and per-register lock and access control behind an AXI4-Lite slave
// assumes sys_clk well above twice the oscillator rate; pins are asynchronous to sys_clk
// Contract
// - clock output selects the divided 1 Hz tick or the 32 kHz oscillator
// - 32.768 kHz selection passes the oscillator through without division
// - wakeup pin is open drain, active low, asserts powered down with interrupt
// - wakeup pin asserts only while wakeup_pin_enable is set
// - seconds interrupt pulses once per second of the time counter
// - seconds interrupt is a pulse with no status flag
// - seconds interrupt drives only while seconds_irq_enable is set
// - seconds interrupt does not drive the wakeup pin, which follows irq only
// - initialised monotonic counter is 64 bits and never goes back
// - overflow of the monotonic counter sets monotonic_overflow_flag
// - overflow interrupt raised from the flag only while its enable is set
// - time seconds captured into tamper_time_seconds when time is invalidated
// - register_lock holds lock bits for count high, low, enable and tamper time
// - write_access holds write permits for counter words, enable and tamper time
// - read_access holds read permits for count high, low, enable and tamper time
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "secure_rtc_map.svh"
module secure_rtc
  import secure_rtc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // axi4-lite write
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins
  input wire logic osc_clk_in,
  input wire logic power_down_in,
  input wire logic tamper_in,
  output logic clock_output_pin,
  output logic wakeup_pin_o,
  output logic wakeup_pin_oe,
  // interrupts
  output logic seconds_irq,
  output logic irq
);
  // pin synchronisers
  logic osc_s1_reg, osc_s2_reg, osc_s3_reg;
  logic pd_s1_reg, pd_s2_reg;
  logic tam_s1_reg, tam_s2_reg, tam_s3_reg;
  logic osc_edge, tamper_edge, tick;
  logic [14:0] div_cnt_reg;
  logic clkout_reg;
  logic [31:0] time_seconds_reg, tamper_time_seconds_reg;
  logic [`CTL_WIDTH-1:0] control_reg;
  logic [`ST_WIDTH-1:0] clock_status_reg, status_set, status_clr;
  logic [`IE_WIDTH-1:0] irq_enable_reg;
  logic [`AC_WIDTH-1:0] register_lock_reg, write_access_reg, read_access_reg;
  logic monotonic_enable_reg;
  logic [63:0] mono_count_reg;
  logic sec_irq_reg, irq_reg, wake_oe_reg;
  // bus state
  logic aw_hold_reg, w_hold_reg, bvalid_reg, rvalid_reg;
  logic [31:0] aw_addr_reg, w_data_reg, rdata_reg;
  logic [3:0] w_strb_reg;
  axi_resp_e bresp_reg, rresp_reg, wr_resp, rd_resp;
  reg_sel_e wr_sel, rd_sel;
  logic do_write, wr_go, rd_take, mono_inc;
  logic [31:0] rd_value;

  function automatic reg_sel_e decode(input logic [31:0] a);
    case (a)
      `OFS_TIME_SECONDS: decode = SEL_TIME;
      `OFS_CONTROL: decode = SEL_CONTROL;
      `OFS_CLOCK_STATUS: decode = SEL_STATUS;
      `OFS_REGISTER_LOCK: decode = SEL_LOCK;
      `OFS_IRQ_ENABLE: decode = SEL_IER;
      `OFS_TAMPER_TIME: decode = SEL_TAMPER;
      `OFS_MONO_ENABLE: decode = SEL_MENABLE;
      `OFS_MONO_LOW: decode = SEL_MLOW;
      `OFS_MONO_HIGH: decode = SEL_MHIGH;
      `OFS_WRITE_ACCESS: decode = SEL_WACCESS;
      `OFS_READ_ACCESS: decode = SEL_RACCESS;
      default: decode = SEL_NONE;
    endcase
  endfunction : decode
  // one-hot of the lock/permit bit that guards a register
  function automatic logic [`AC_WIDTH-1:0] guard(input reg_sel_e s);
    guard = `AC_NONE;
    case (s)
      SEL_MHIGH: guard[`AC_HIGH] = 1'b1;
      SEL_MLOW: guard[`AC_LOW] = 1'b1;
      SEL_MENABLE: guard[`AC_ENABLE] = 1'b1;
      SEL_TAMPER: guard[`AC_TAMPER] = 1'b1;
      default: guard = `AC_NONE;
    endcase
  endfunction : guard

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction : merge
  // synchronisers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_s1_reg <= 1'b0;
      osc_s2_reg <= 1'b0;
      osc_s3_reg <= 1'b0;
      pd_s1_reg <= 1'b0;
      pd_s2_reg <= 1'b0;
      tam_s1_reg <= 1'b0;
      tam_s2_reg <= 1'b0;
      tam_s3_reg <= 1'b0;
    end else begin
      osc_s1_reg <= osc_clk_in;
      osc_s2_reg <= osc_s1_reg;
      osc_s3_reg <= osc_s2_reg;
      pd_s1_reg <= power_down_in;
      pd_s2_reg <= pd_s1_reg;
      tam_s1_reg <= tamper_in;
      tam_s2_reg <= tam_s1_reg;
      tam_s3_reg <= tam_s2_reg;
    end
  end

  assign osc_edge = osc_s2_reg & ~osc_s3_reg;
  assign tamper_edge = tam_s2_reg & ~tam_s3_reg;
  assign tick = osc_edge && (div_cnt_reg == `OSC_DIV_LAST);
  // oscillator divider and clock output mux
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_reg <= '0;
      clkout_reg <= 1'b0;
    end else begin
      if (osc_edge) begin
        div_cnt_reg <= div_cnt_reg + 15'h0001;
      end
      if (control_reg[`CTL_CLKOUT_SEL]) begin
        clkout_reg <= osc_s2_reg;
      end else begin
        clkout_reg <= div_cnt_reg[`DIV_HALF_BIT];
      end
    end
  end
  // time seconds counter and seconds pulse
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      time_seconds_reg <= '0;
      sec_irq_reg <= 1'b0;
    end else begin
      if (wr_go && wr_sel == SEL_TIME) begin
        time_seconds_reg <= merge(time_seconds_reg, w_data_reg, w_strb_reg);
      end else if (tick && control_reg[`CTL_TIME_EN]) begin
        time_seconds_reg <= time_seconds_reg + 32'h0000_0001;
      end
      sec_irq_reg <= tick && control_reg[`CTL_TIME_EN] && irq_enable_reg[`IE_SECONDS_IRQ_ENABLE];
    end
  end
  // tamper capture
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tamper_time_seconds_reg <= '0;
    end else if (tamper_edge) begin
      tamper_time_seconds_reg <= time_seconds_reg;
    end
  end
  // monotonic counter
  assign mono_inc = wr_go && monotonic_enable_reg && (wr_sel == SEL_MLOW || wr_sel == SEL_MHIGH);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mono_count_reg <= '0;
    end else if (mono_inc) begin
      if (!(&mono_count_reg)) begin
        mono_count_reg <= mono_count_reg + 64'h0000_0000_0000_0001;
      end
    end else if (wr_go && wr_sel == SEL_MLOW) begin
      mono_count_reg[31:0] <= merge(mono_count_reg[31:0], w_data_reg, w_strb_reg);
    end else if (wr_go && wr_sel == SEL_MHIGH) begin
      mono_count_reg[63:32] <= merge(mono_count_reg[63:32], w_data_reg, w_strb_reg);
    end
  end
  // status flags, set wins over write-one-to-clear
  always_comb begin
    status_set = '0;
    status_set[`ST_MOF] = mono_inc && (&mono_count_reg);
    status_set[`ST_TIF] = tamper_edge;
    status_clr = '0;
    if (wr_go && wr_sel == SEL_STATUS) begin
      status_clr = w_data_reg[`ST_WIDTH-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clock_status_reg <= '0;
    end else begin
      clock_status_reg <= (clock_status_reg & ~status_clr) | status_set;
    end
  end
  // control registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      control_reg <= `CTL_RESET;
      irq_enable_reg <= `IE_RESET;
      monotonic_enable_reg <= 1'b0;
    end else begin
      if (wr_go && wr_sel == SEL_CONTROL) begin
        control_reg <= w_data_reg[`CTL_WIDTH-1:0];
      end
      if (wr_go && wr_sel == SEL_IER) begin
        irq_enable_reg <= w_data_reg[`IE_WIDTH-1:0];
      end
      if (wr_go && wr_sel == SEL_MENABLE) begin
        monotonic_enable_reg <= w_data_reg[`ME_EN];
      end
    end
  end
  // lock and permit bits only ever clear until reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      register_lock_reg <= `AC_RESET;
      write_access_reg <= `AC_RESET;
      read_access_reg <= `AC_RESET;
    end else begin
      if (wr_go && wr_sel == SEL_LOCK) begin
        register_lock_reg <= register_lock_reg & w_data_reg[`AC_WIDTH-1:0];
      end
      if (wr_go && wr_sel == SEL_WACCESS) begin
        write_access_reg <= write_access_reg & w_data_reg[`AC_WIDTH-1:0];
      end
      if (wr_go && wr_sel == SEL_RACCESS) begin
        read_access_reg <= read_access_reg & w_data_reg[`AC_WIDTH-1:0];
      end
    end
  end
  // interrupt and wakeup pin
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
      wake_oe_reg <= 1'b0;
    end else begin
      irq_reg <= |(clock_status_reg & irq_enable_reg[`ST_WIDTH-1:0]);
      wake_oe_reg <= pd_s2_reg && irq_reg && irq_enable_reg[`IE_WAKEUP_PIN_ENABLE];
    end
  end

  assign clock_output_pin = clkout_reg;
  assign wakeup_pin_o = 1'b0;
  assign wakeup_pin_oe = wake_oe_reg;
  assign seconds_irq = sec_irq_reg;
  assign irq = irq_reg;
  // axi write channel
  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready = !w_hold_reg && !bvalid_reg;
  assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign wr_sel = decode(aw_addr_reg);
  always_comb begin
    if (wr_sel == SEL_NONE) begin
      wr_resp = RESP_DECERR;
    end else if (|(guard(wr_sel) & ~write_access_reg)) begin
      wr_resp = RESP_SLVERR;
    end else begin
      wr_resp = RESP_OKAY;
    end
  end
  assign wr_go = do_write && wr_resp == RESP_OKAY && !(|(guard(wr_sel) & ~register_lock_reg)) &&
                 wr_sel != SEL_TAMPER;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_resp;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  // axi read channel
  assign s_axi_arready = !rvalid_reg;
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign rd_sel = decode(s_axi_araddr);
  always_comb begin
    rd_value = '0;
    rd_resp = RESP_OKAY;
    case (rd_sel)
      SEL_TIME: rd_value = time_seconds_reg;
      SEL_CONTROL: rd_value[`CTL_WIDTH-1:0] = control_reg;
      SEL_STATUS: rd_value[`ST_WIDTH-1:0] = clock_status_reg;
      SEL_LOCK: rd_value[`AC_WIDTH-1:0] = register_lock_reg;
      SEL_IER: rd_value[`IE_WIDTH-1:0] = irq_enable_reg;
      SEL_TAMPER: rd_value = tamper_time_seconds_reg;
      SEL_MENABLE: rd_value[`ME_EN] = monotonic_enable_reg;
      SEL_MLOW: rd_value = mono_count_reg[31:0];
      SEL_MHIGH: rd_value = mono_count_reg[63:32];
      SEL_WACCESS: rd_value[`AC_WIDTH-1:0] = write_access_reg;
      SEL_RACCESS: rd_value[`AC_WIDTH-1:0] = read_access_reg;
      default: rd_resp = RESP_DECERR;
    endcase
    if (|(guard(rd_sel) & ~read_access_reg)) begin
      rd_resp = RESP_SLVERR;
      rd_value = '0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else if (rd_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_value;
      rresp_reg <= rd_resp;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_clkout_pass: assert property (control_reg[`CTL_CLKOUT_SEL] |=>
    clock_output_pin == $past(osc_s2_reg)) else $error("clock output not the oscillator");
  a_clkout_tick: assert property (!control_reg[`CTL_CLKOUT_SEL] |=>
    clock_output_pin == $past(div_cnt_reg[`DIV_HALF_BIT])) else $error("clock output not 1 Hz");
  a_wake_cause: assert property (wakeup_pin_oe |->
    $past(pd_s2_reg) && $past(irq_reg) && wakeup_pin_o == 1'b0) else $error("wakeup without cause");
  a_wake_gate: assert property (!irq_enable_reg[`IE_WAKEUP_PIN_ENABLE] |=>
    !wakeup_pin_oe) else $error("wakeup pin while disabled");
  a_sec_pulse: assert property (tick && control_reg[`CTL_TIME_EN] &&
    irq_enable_reg[`IE_SECONDS_IRQ_ENABLE] |=> seconds_irq ##1 !seconds_irq) else $error("seconds pulse wrong");
  a_sec_gate: assert property (seconds_irq |->
    $past(irq_enable_reg[`IE_SECONDS_IRQ_ENABLE]) && $past(tick)) else $error("seconds pulse not enabled");
  a_mono_forward: assert property ($past(monotonic_enable_reg) && monotonic_enable_reg |->
    mono_count_reg >= $past(mono_count_reg)) else $error("counter went back");
  a_ovf_flag: assert property (mono_inc && (&mono_count_reg) |=>
    clock_status_reg[`ST_MOF] && (&mono_count_reg)) else $error("overflow flag missing");
  a_ovf_irq: assert property (clock_status_reg[`ST_MOF] && irq_enable_reg[`IE_MONOTONIC_OVERFLOW_IRQ_ENABLE] |=>
    irq) else $error("overflow interrupt missing");
  a_tamper_capture: assert property (tamper_edge |=>
    tamper_time_seconds_reg == $past(time_seconds_reg)) else $error("tamper time not captured");
  a_lock_sticky: assert property (!register_lock_reg[`AC_LOW] |=>
    !register_lock_reg[`AC_LOW] && $stable(mono_count_reg[31:0]) ||
    monotonic_enable_reg) else $error("locked low word changed");
  a_perm_error: assert property (do_write && |(guard(wr_sel) & ~write_access_reg) |=>
    s_axi_bvalid && s_axi_bresp == RESP_SLVERR) else $error("denied write not refused");

  c_seconds: cover property (seconds_irq);
  c_overflow: cover property (status_set[`ST_MOF]);
  c_tamper: cover property (tamper_edge);
  c_denied_read: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule : secure_rtc

// ---- logic/secure_rtc_map.svh ----
// register offsets, field positions, reset values and divider counts of the secure clock
// assumes byte addresses on a 32-bit register bus, one aligned word per register
`ifndef SECURE_RTC_MAP_SVH
`define SECURE_RTC_MAP_SVH
`define OFS_TIME_SECONDS 32'h4003_d000
`define OFS_CONTROL 32'h4003_d010
`define OFS_CLOCK_STATUS 32'h4003_d014
`define OFS_REGISTER_LOCK 32'h4003_d018
`define OFS_IRQ_ENABLE 32'h4003_d01c
`define OFS_TAMPER_TIME 32'h4003_d020
`define OFS_MONO_ENABLE 32'h4003_d024
`define OFS_MONO_LOW 32'h4003_d028
`define OFS_MONO_HIGH 32'h4003_d02c
`define OFS_WRITE_ACCESS 32'h4003_d030
`define OFS_READ_ACCESS 32'h4003_d034
`define CTL_CLKOUT_SEL 0
`define CTL_TIME_EN 1
`define CTL_WIDTH 2
`define CTL_RESET 2'h0
`define ST_MOF 0
`define ST_TIF 1
`define ST_WIDTH 2
`define IE_MONOTONIC_OVERFLOW_IRQ_ENABLE 0
`define IE_TIIE 1
`define IE_SECONDS_IRQ_ENABLE 4
`define IE_WAKEUP_PIN_ENABLE 7
`define IE_WIDTH 8
`define IE_RESET 8'h00
`define ME_EN 0
`define AC_HIGH 0
`define AC_LOW 1
`define AC_ENABLE 2
`define AC_TAMPER 3
`define AC_WIDTH 4
`define AC_RESET 4'hf
`define AC_NONE 4'h0
`define OSC_DIV_LAST 15'h7fff
`define DIV_HALF_BIT 14
`endif

// ---- logic/secure_rtc_pkg.sv ----
// types shared by the secure clock block
// assumes nothing of its surroundings
package secure_rtc_pkg;
  typedef enum logic [1:0] {
    RESP_OKAY = 2'h0,
    RESP_SLVERR = 2'h2,
    RESP_DECERR = 2'h3
  } axi_resp_e;
  typedef enum logic [3:0] {
    SEL_NONE = 4'h0, SEL_TIME = 4'h1, SEL_CONTROL = 4'h2, SEL_STATUS = 4'h3,
    SEL_LOCK = 4'h4, SEL_IER = 4'h5, SEL_TAMPER = 4'h6, SEL_MENABLE = 4'h7,
    SEL_MLOW = 4'h8, SEL_MHIGH = 4'h9, SEL_WACCESS = 4'ha, SEL_RACCESS = 4'hb
  } reg_sel_e;
endpackage : secure_rtc_pkg

// ---- sim/tb_top.sv ----
// self-checking bench for the secure clock block: axi4-lite register tasks and pin checks
// assumes the register map header and package of the design; one 125 MHz clock
`timescale 1ns/10ps
`include "secure_rtc_map.svh"
module tb_top
  import secure_rtc_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] awaddr = '0;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = '0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [31:0] araddr = '0;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic osc_clk_in = 1'b0;
  logic osc_run = 1'b0;
  logic osc_level = 1'b0;
  logic [1:0] osc_ph = 2'h0;
  logic power_down_in = 1'b0;
  logic tamper_in = 1'b0;
  logic clock_output_pin;
  logic wakeup_pin_o;
  logic wakeup_pin_oe;
  logic seconds_irq;
  logic irq;
  logic count_en = 1'b0;
  logic pin_prev = 1'b0;
  int pulse_cnt = 0;
  int pin_chg = 0;
  int err_total = 0;
  int cmp_count = 0;
  int cycles = 0;

  always #4 sys_clk = ~sys_clk;

  secure_rtc i_secure_rtc (
    .sys_clk(sys_clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .osc_clk_in(osc_clk_in), .power_down_in(power_down_in), .tamper_in(tamper_in),
    .clock_output_pin(clock_output_pin), .wakeup_pin_o(wakeup_pin_o),
    .wakeup_pin_oe(wakeup_pin_oe), .seconds_irq(seconds_irq), .irq(irq)
  );

  // oscillator: two cycles high, one low while running, else a static level
  always @(posedge sys_clk) begin
    if (osc_run) begin
      osc_ph <= (osc_ph == 2'h2) ? 2'h0 : osc_ph + 2'h1;
      osc_clk_in <= (osc_ph != 2'h2);
    end else begin
      osc_clk_in <= osc_level;
    end
  end

  // pulse and clock output edge counting, plus watchdog
  always @(posedge sys_clk) begin
    pin_prev <= clock_output_pin;
    if (count_en) begin
      if (seconds_irq === 1'b1) pulse_cnt++;
      if (clock_output_pin !== pin_prev) pin_chg++;
    end
    cycles++;
    if (cycles == 101000) begin
      err_total++;
      $display("ERROR %0t watchdog expired", $time);
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t data got %h exp %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t response got %h exp %h", $time, got, exp);
    end
  endtask : chk_resp

  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t pin got %b exp %b", $time, got, exp);
    end
  endtask : chk_bit

  // write: address and data offered together, each released when taken
  task automatic wr(input logic [31:0] addr, input logic [31:0] data,
                    input logic [1:0] exp_resp = RESP_OKAY);
    logic [1:0] resp;
    awaddr <= addr;
    wdata <= data;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    resp = 2'h1;
    do begin
      @(posedge sys_clk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        resp = bresp;
        bready <= 1'b0;
      end
    end while (bvalid !== 1'b1);
    @(posedge sys_clk);
    chk_resp(resp, exp_resp);
  endtask : wr

  task automatic rd(input logic [31:0] addr, input logic [31:0] exp_data,
                    input logic [1:0] exp_resp = RESP_OKAY);
    logic [31:0] data;
    logic [1:0] resp;
    araddr <= addr;
    arvalid <= 1'b1;
    rready <= 1'b1;
    data = '0;
    resp = 2'h1;
    do begin
      @(posedge sys_clk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        data = rdata;
        resp = rresp;
        rready <= 1'b0;
      end
    end while (rvalid !== 1'b1);
    @(posedge sys_clk);
    chk_resp(resp, exp_resp);
    chk_word(data, exp_data);
  endtask : rd

  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    // reset values
    rd(`OFS_IRQ_ENABLE, 32'h0000_0000);
    rd(`OFS_REGISTER_LOCK, 32'h0000_000f);
    rd(`OFS_WRITE_ACCESS, 32'h0000_000f);
    rd(`OFS_READ_ACCESS, 32'h0000_000f);
    rd(`OFS_MONO_ENABLE, 32'h0000_0000);
    rd(`OFS_CLOCK_STATUS, 32'h0000_0000);
    rd(`OFS_CONTROL, 32'h0000_0000);
    rd(`OFS_MONO_LOW, 32'h0000_0000);
    // unmapped place
    rd(32'h4003_d040, 32'h0000_0000, RESP_DECERR);
    wr(32'h4003_d040, 32'h0000_0001, RESP_DECERR);
    // one second of oscillator, chip powered down, time counter and seconds pulse enabled
    wr(`OFS_CONTROL, 32'h0000_0002);
    wr(`OFS_IRQ_ENABLE, 32'h0000_0010);
    count_en <= 1'b1;
    osc_run <= 1'b1;
    power_down_in <= 1'b1;
    repeat (32768 * 3 + 40) @(posedge sys_clk);
    osc_run <= 1'b0;
    count_en <= 1'b0;
    power_down_in <= 1'b0;
    @(posedge sys_clk);
    chk_word(32'(pulse_cnt), 32'h0000_0001);
    chk_bit(seconds_irq, 1'b0);
    chk_word(32'(pin_chg), 32'h0000_0002);
    rd(`OFS_TIME_SECONDS, 32'h0000_0001);
    rd(`OFS_CLOCK_STATUS, 32'h0000_0000);
    // oscillator passed straight to the clock output
    wr(`OFS_CONTROL, 32'h0000_0001);
    osc_level <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk_bit(clock_output_pin, 1'b1);
    osc_level <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk_bit(clock_output_pin, 1'b0);
    // tamper capture of time seconds
    tamper_in <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rd(`OFS_TAMPER_TIME, 32'h0000_0001);
    wr(`OFS_TAMPER_TIME, 32'h0000_0055);
    rd(`OFS_TAMPER_TIME, 32'h0000_0001);
    rd(`OFS_CLOCK_STATUS, 32'h0000_0002);
    // monotonic counter increment and overflow
    wr(`OFS_CLOCK_STATUS, 32'h0000_0003);
    wr(`OFS_MONO_LOW, 32'hffff_fffe);
    wr(`OFS_MONO_HIGH, 32'hffff_ffff);
    wr(`OFS_MONO_ENABLE, 32'h0000_0001);
    wr(`OFS_MONO_LOW, 32'h0000_0000);
    rd(`OFS_MONO_LOW, 32'hffff_ffff);
    rd(`OFS_MONO_HIGH, 32'hffff_ffff);
    rd(`OFS_CLOCK_STATUS, 32'h0000_0000);
    wr(`OFS_MONO_HIGH, 32'h0000_0000);
    rd(`OFS_MONO_LOW, 32'hffff_ffff);
    rd(`OFS_MONO_HIGH, 32'hffff_ffff);
    rd(`OFS_CLOCK_STATUS, 32'h0000_0001);
    wr(`OFS_IRQ_ENABLE, 32'h0000_0000);
    repeat (3) @(posedge sys_clk);
    chk_bit(irq, 1'b0);
    wr(`OFS_IRQ_ENABLE, 32'h0000_0001);
    repeat (3) @(posedge sys_clk);
    chk_bit(irq, 1'b1);
    // wakeup pin
    power_down_in <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk_bit(wakeup_pin_oe, 1'b0);
    wr(`OFS_IRQ_ENABLE, 32'h0000_0081);
    repeat (6) @(posedge sys_clk);
    chk_bit(wakeup_pin_oe, 1'b1);
    chk_bit(wakeup_pin_o, 1'b0);
    power_down_in <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk_bit(wakeup_pin_oe, 1'b0);
    power_down_in <= 1'b1;
    wr(`OFS_CLOCK_STATUS, 32'h0000_0001);
    repeat (6) @(posedge sys_clk);
    chk_bit(irq, 1'b0);
    chk_bit(wakeup_pin_oe, 1'b0);
    // lock of the enable register, held until reset
    wr(`OFS_REGISTER_LOCK, 32'h0000_000b);
    wr(`OFS_MONO_ENABLE, 32'h0000_0000);
    rd(`OFS_MONO_ENABLE, 32'h0000_0001);
    wr(`OFS_REGISTER_LOCK, 32'h0000_000f);
    rd(`OFS_REGISTER_LOCK, 32'h0000_000b);
    // read and write permits
    wr(`OFS_READ_ACCESS, 32'h0000_000e);
    rd(`OFS_MONO_HIGH, 32'h0000_0000, RESP_SLVERR);
    rd(`OFS_MONO_LOW, 32'hffff_ffff);
    wr(`OFS_WRITE_ACCESS, 32'h0000_000d);
    wr(`OFS_MONO_LOW, 32'h0000_0000, RESP_SLVERR);
    rd(`OFS_WRITE_ACCESS, 32'h0000_000d);
    report_and_stop();
  end
endmodule : tb_top
